// file: design/dtc_config_regs.sv
// Adaptive floor configuration registers with AXI4-Lite access
// Functional notes
// - Target registers reset to 0x64, 100 C
// - Enabled channel regulates about its target register
// - Lock bit makes target and control registers ignore writes
// - Control bit 0 is far2 cycle MSB
// - Cycle code sets monitoring cycles between adjustments
// - Core low in standby sets status, alert
// - Core low disables hot monitor, adaptive, shutdown
// - Capture far1 temperature on overheat assertion
// - Capture local temperature on overheat assertion
// - Capture far2 temperature on overheat assertion
// - Capture bit clear keeps programmed target
// - Bits 5-7 enable adaptive floor per channel
// - Disabled channel keeps programmed floor unchanged
`timescale 1ns/1ps
module dtc_config_regs (
    input  wire logic                       clock_i,
    input  wire logic                       rst_n_i,
    // AXI4-Lite slave
    input  wire logic [dtc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    input  wire logic [dtc_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic [31:0]                     s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    // Pins
    input  wire logic                       overheat_pin_n_i,
    input  wire logic                       standby_supply_i,
    // Measurements from the monitoring core, same clock
    input  wire logic                       monitor_tick_i,
    input  wire logic [7:0]                 core_voltage_i,
    input  wire logic [7:0]                 far1_temp_i,
    input  wire logic [7:0]                 local_temp_i,
    input  wire logic [7:0]                 far2_temp_i,
    input  wire logic [7:0]                 far1_low_lim_i,
    input  wire logic [7:0]                 local_low_lim_i,
    input  wire logic [7:0]                 far2_low_lim_i,
    input  wire logic [7:0]                 far1_high_lim_i,
    input  wire logic [7:0]                 local_high_lim_i,
    input  wire logic [7:0]                 far2_high_lim_i,
    input  wire logic [7:0]                 far1_prog_floor_i,
    input  wire logic [7:0]                 local_prog_floor_i,
    input  wire logic [7:0]                 far2_prog_floor_i,
    // Results
    output logic [7:0]                      far1_floor_o,
    output logic [7:0]                      local_floor_o,
    output logic [7:0]                      far2_floor_o,
    output logic [2:0]                      adaptive_active_o,
    output logic                            processor_hot_monitor_en_o,
    output logic                            shutdown_block_o,
    output logic                            irq_o
);
    // Register state
    logic [7:0] far1_tgt_ff;
    logic [7:0] local_tgt_ff;
    logic [7:0] far2_tgt_ff;
    logic [7:0] ctrl_one_ff;
    logic [7:0] ctrl_two_ff;
    logic       lock_ff;
    logic [1:0] status_ff;
    logic [1:0] mask_ff;
    logic [7:0] core_lolim_ff;
    logic       hot_prev_ff;
    logic       cvl_ff;
    logic       irq_ff;
    logic       phm_en_ff;
    logic       shut_blk_ff;
    logic [2:0] active_ff;
    logic                       awready_ff;
    logic                       bvalid_ff;
    logic [1:0]                 bresp_ff;
    logic                       arready_ff;
    logic                       rvalid_ff;
    logic [31:0]                rdata_ff;
    logic [1:0]                 rresp_ff;

    logic [1:0] pins_sync;

    dtc_sync2 #(
        .W(2)
    ) u_pin_sync (
        .clock_i  (clock_i),
        .rst_n_i  (rst_n_i),
        .async_i  ({standby_supply_i, overheat_pin_n_i}),
        .rst_val_i(2'h1),
        .sync_o   (pins_sync)
    );

    wire overheat_now = !pins_sync[0];
    wire on_standby   = pins_sync[1];
    wire overheat_rise = overheat_now && !hot_prev_ff;

    // Write channel: both address and data taken together
    wire wr_fire  = s_axi_awvalid && s_axi_wvalid && !bvalid_ff && !awready_ff;
    wire [dtc_pkg::IDX_W-1:0] wr_idx = s_axi_awaddr[dtc_pkg::ADDR_W-1:2];
    wire wr_lane0 = wr_fire && s_axi_wstrb[0];
    wire [7:0] wbyte = s_axi_wdata[7:0];

    wire hit_w_far1   = wr_idx == dtc_pkg::IDX_FAR1_TGT;
    wire hit_w_local  = wr_idx == dtc_pkg::IDX_LOCAL_TGT;
    wire hit_w_far2   = wr_idx == dtc_pkg::IDX_FAR2_TGT;
    wire hit_w_ctl1   = wr_idx == dtc_pkg::IDX_CTRL_ONE;
    wire hit_w_ctl2   = wr_idx == dtc_pkg::IDX_CTRL_TWO;
    wire hit_w_cfg    = wr_idx == dtc_pkg::IDX_CONFIG;
    wire hit_w_sts    = wr_idx == dtc_pkg::IDX_STATUS;
    wire hit_w_lolim  = wr_idx == dtc_pkg::IDX_CORE_LOLIM;
    wire hit_w_mask   = wr_idx == dtc_pkg::IDX_IRQ_MASK;
    wire wr_mapped    = hit_w_far1 | hit_w_local | hit_w_far2 | hit_w_ctl1 | hit_w_ctl2
                      | hit_w_cfg | hit_w_sts | hit_w_lolim | hit_w_mask;

    wire wr_open      = wr_lane0 && !lock_ff;
    wire we_far1      = wr_open && hit_w_far1;
    wire we_local     = wr_open && hit_w_local;
    wire we_far2      = wr_open && hit_w_far2;
    wire we_ctl1      = wr_open && hit_w_ctl1;
    wire we_ctl2      = wr_open && hit_w_ctl2;
    wire we_cfg       = wr_lane0 && hit_w_cfg;
    wire we_sts       = wr_lane0 && hit_w_sts;
    wire we_lolim     = wr_lane0 && hit_w_lolim;
    wire we_mask      = wr_lane0 && hit_w_mask;

    wire cap_far1   = overheat_rise && ctrl_one_ff[dtc_pkg::CTL_FAR1_CAP];
    wire cap_local  = overheat_rise && ctrl_one_ff[dtc_pkg::CTL_LOCAL_CAP];
    wire cap_far2   = overheat_rise && ctrl_one_ff[dtc_pkg::CTL_FAR2_CAP];

    wire cvl_now = ctrl_one_ff[dtc_pkg::CTL_CVL_MODE] && on_standby
                 && (core_voltage_i < core_lolim_ff);

    // Cycle codes, far2 MSB in control one
    wire [2:0] far1_code  = ctrl_two_ff[dtc_pkg::CT2_FAR1_CYC_LSB +: 3];
    wire [2:0] local_code = ctrl_two_ff[dtc_pkg::CT2_LOCAL_CYC_LSB +: 3];
    wire [2:0] far2_code  = {ctrl_one_ff[dtc_pkg::CTL_FAR2_CYC_MSB],
                             ctrl_two_ff[dtc_pkg::CT2_FAR2_CYC_LSB +: 2]};

    wire [2:0] adapt_en = {ctrl_one_ff[dtc_pkg::CTL_FAR2_EN],
                           ctrl_one_ff[dtc_pkg::CTL_LOCAL_EN],
                           ctrl_one_ff[dtc_pkg::CTL_FAR1_EN]} & {3{!cvl_ff}};

    wire [1:0] sts_events = {cvl_ff, cap_far1 | cap_local | cap_far2};
    wire [1:0] sts_clear  = we_sts ? wbyte[1:0] : 2'h0;

    // Read channel
    wire rd_fire = s_axi_arvalid && !rvalid_ff && !arready_ff;
    wire [dtc_pkg::IDX_W-1:0] rd_idx = s_axi_araddr[dtc_pkg::ADDR_W-1:2];
    wire hit_r_far1   = rd_idx == dtc_pkg::IDX_FAR1_TGT;
    wire hit_r_local  = rd_idx == dtc_pkg::IDX_LOCAL_TGT;
    wire hit_r_far2   = rd_idx == dtc_pkg::IDX_FAR2_TGT;
    wire hit_r_ctl1   = rd_idx == dtc_pkg::IDX_CTRL_ONE;
    wire hit_r_ctl2   = rd_idx == dtc_pkg::IDX_CTRL_TWO;
    wire hit_r_cfg    = rd_idx == dtc_pkg::IDX_CONFIG;
    wire hit_r_sts    = rd_idx == dtc_pkg::IDX_STATUS;
    wire hit_r_lolim  = rd_idx == dtc_pkg::IDX_CORE_LOLIM;
    wire hit_r_mask   = rd_idx == dtc_pkg::IDX_IRQ_MASK;
    wire rd_mapped    = hit_r_far1 | hit_r_local | hit_r_far2 | hit_r_ctl1 | hit_r_ctl2
                      | hit_r_cfg | hit_r_sts | hit_r_lolim | hit_r_mask;
    wire [7:0] rd_byte = ({8{hit_r_far1}}  & far1_tgt_ff)
                       | ({8{hit_r_local}} & local_tgt_ff)
                       | ({8{hit_r_far2}}  & far2_tgt_ff)
                       | ({8{hit_r_ctl1}}  & ctrl_one_ff)
                       | ({8{hit_r_ctl2}}  & ctrl_two_ff)
                       | ({8{hit_r_cfg}}   & {6'h00, lock_ff, 1'b0})
                       | ({8{hit_r_sts}}   & {6'h00, status_ff})
                       | ({8{hit_r_lolim}} & core_lolim_ff)
                       | ({8{hit_r_mask}}  & {6'h00, mask_ff});

    dtc_floor_adj u_far1_adj (
        .clock_i       (clock_i),
        .rst_n_i       (rst_n_i),
        .enable_i      (adapt_en[0]),
        .monitor_tick_i(monitor_tick_i),
        .cycle_code_i  (far1_code),
        .temp_i        (far1_temp_i),
        .target_i      (far1_tgt_ff),
        .low_limit_i   (far1_low_lim_i),
        .high_limit_i  (far1_high_lim_i),
        .prog_floor_i  (far1_prog_floor_i),
        .floor_o       (far1_floor_o)
    );

    dtc_floor_adj u_local_adj (
        .clock_i       (clock_i),
        .rst_n_i       (rst_n_i),
        .enable_i      (adapt_en[1]),
        .monitor_tick_i(monitor_tick_i),
        .cycle_code_i  (local_code),
        .temp_i        (local_temp_i),
        .target_i      (local_tgt_ff),
        .low_limit_i   (local_low_lim_i),
        .high_limit_i  (local_high_lim_i),
        .prog_floor_i  (local_prog_floor_i),
        .floor_o       (local_floor_o)
    );

    dtc_floor_adj u_far2_adj (
        .clock_i       (clock_i),
        .rst_n_i       (rst_n_i),
        .enable_i      (adapt_en[2]),
        .monitor_tick_i(monitor_tick_i),
        .cycle_code_i  (far2_code),
        .temp_i        (far2_temp_i),
        .target_i      (far2_tgt_ff),
        .low_limit_i   (far2_low_lim_i),
        .high_limit_i  (far2_high_lim_i),
        .prog_floor_i  (far2_prog_floor_i),
        .floor_o       (far2_floor_o)
    );

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            far1_tgt_ff <= dtc_pkg::RST_TARGET;
        end else if (cap_far1) begin
            far1_tgt_ff <= far1_temp_i;
        end else if (we_far1) begin
            far1_tgt_ff <= wbyte;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            local_tgt_ff <= dtc_pkg::RST_TARGET;
        end else if (cap_local) begin
            local_tgt_ff <= local_temp_i;
        end else if (we_local) begin
            local_tgt_ff <= wbyte;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            far2_tgt_ff <= dtc_pkg::RST_TARGET;
        end else if (cap_far2) begin
            far2_tgt_ff <= far2_temp_i;
        end else if (we_far2) begin
            far2_tgt_ff <= wbyte;
        end
    end

    // Control, config, limit and mask registers
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            ctrl_one_ff   <= dtc_pkg::RST_CTRL;
            ctrl_two_ff   <= dtc_pkg::RST_CTRL;
            lock_ff       <= 1'b0;
            core_lolim_ff <= dtc_pkg::RST_LOLIM;
            mask_ff       <= dtc_pkg::RST_MASK[1:0];
        end else begin
            if (we_ctl1) begin
                ctrl_one_ff <= wbyte;
            end
            if (we_ctl2) begin
                ctrl_two_ff <= wbyte;
            end
            if (we_cfg && wbyte[dtc_pkg::CFG_LOCK]) begin
                lock_ff <= 1'b1;
            end
            if (we_lolim) begin
                core_lolim_ff <= wbyte;
            end
            if (we_mask) begin
                mask_ff <= wbyte[1:0];
            end
        end
    end

    // Sticky status, set wins over clear
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            status_ff <= 2'h0;
        end else begin
            status_ff <= (status_ff & ~sts_clear) | sts_events;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            hot_prev_ff <= 1'b0;
            cvl_ff      <= 1'b0;
            phm_en_ff   <= 1'b1;
            shut_blk_ff <= 1'b0;
            active_ff   <= 3'h0;
            irq_ff      <= 1'b0;
        end else begin
            hot_prev_ff <= overheat_now;
            cvl_ff      <= cvl_now;
            phm_en_ff   <= !cvl_ff;
            shut_blk_ff <= cvl_ff;
            active_ff   <= adapt_en;
            irq_ff      <= |(status_ff & mask_ff);
        end
    end

    // AXI4-Lite write handshake and response
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            awready_ff <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= dtc_pkg::RESP_OKAY;
        end else begin
            awready_ff <= wr_fire;
            if (wr_fire) begin
                bvalid_ff <= 1'b1;
                bresp_ff  <= wr_mapped ? dtc_pkg::RESP_OKAY : dtc_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // AXI4-Lite read handshake and data
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
            rresp_ff   <= dtc_pkg::RESP_OKAY;
        end else begin
            arready_ff <= rd_fire;
            if (rd_fire) begin
                rvalid_ff <= 1'b1;
                rdata_ff  <= {24'h000000, rd_byte};
                rresp_ff  <= rd_mapped ? dtc_pkg::RESP_OKAY : dtc_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    assign s_axi_awready              = awready_ff;
    assign s_axi_wready               = awready_ff;
    assign s_axi_bvalid               = bvalid_ff;
    assign s_axi_bresp                = bresp_ff;
    assign s_axi_arready              = arready_ff;
    assign s_axi_rvalid               = rvalid_ff;
    assign s_axi_rdata                = rdata_ff;
    assign s_axi_rresp                = rresp_ff;
    assign adaptive_active_o          = active_ff;
    assign processor_hot_monitor_en_o = phm_en_ff;
    assign shutdown_block_o           = shut_blk_ff;
    assign irq_o                      = irq_ff;
endmodule // dtc_config_regs

// file: design/dtc_floor_adj.sv
// Per-channel minimum temperature adjustment loop
`timescale 1ns/1ps
module dtc_floor_adj (
    input  wire logic       clock_i,
    input  wire logic       rst_n_i,
    input  wire logic       enable_i,
    input  wire logic       monitor_tick_i,
    input  wire logic [2:0] cycle_code_i,
    input  wire logic [7:0] temp_i,
    input  wire logic [7:0] target_i,
    input  wire logic [7:0] low_limit_i,
    input  wire logic [7:0] high_limit_i,
    input  wire logic [7:0] prog_floor_i,
    output logic      [7:0] floor_o
);
    logic [dtc_pkg::CYC_W-1:0] cnt_ff;
    logic [7:0]                floor_ff;

    wire [dtc_pkg::CYC_W-1:0] dec_period = dtc_pkg::DEC_BASE << cycle_code_i;
    wire [dtc_pkg::CYC_W-1:0] inc_period = dtc_pkg::INC_BASE << cycle_code_i;
    wire too_hot  = $signed(temp_i) > $signed(target_i);
    wire too_cool = $signed(temp_i) < $signed(low_limit_i);
    wire can_dec  = $signed(floor_ff) > $signed(low_limit_i);
    wire can_inc  = $signed(floor_ff) < $signed(high_limit_i);
    wire dec_due  = too_hot && (cnt_ff >= dec_period - 11'h001);
    wire inc_due  = too_cool && (cnt_ff >= inc_period - 11'h001);

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            cnt_ff   <= '0;
            floor_ff <= 8'h00;
        end else if (!enable_i) begin
            cnt_ff   <= '0;
            floor_ff <= prog_floor_i;
        end else if (monitor_tick_i) begin
            if (dec_due || inc_due || !(too_hot || too_cool)) begin
                cnt_ff <= '0;
            end else begin
                cnt_ff <= cnt_ff + 11'h001;
            end
            if (dec_due && can_dec) begin
                floor_ff <= floor_ff - 8'h01;
            end else if (inc_due && can_inc) begin
                floor_ff <= floor_ff + 8'h01;
            end
        end
    end

    assign floor_o = floor_ff;
endmodule // dtc_floor_adj

// file: design/dtc_pkg.sv
// Shared constants for the adaptive floor configuration block
package dtc_pkg;
    localparam int unsigned ADDR_W          = 12;
    localparam int unsigned IDX_W           = 10;
    // Register indexes; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_FAR1_TGT   = 10'h033;
    localparam logic [IDX_W-1:0] IDX_LOCAL_TGT  = 10'h034;
    localparam logic [IDX_W-1:0] IDX_FAR2_TGT   = 10'h035;
    localparam logic [IDX_W-1:0] IDX_CTRL_ONE   = 10'h036;
    localparam logic [IDX_W-1:0] IDX_CTRL_TWO   = 10'h037;
    localparam logic [IDX_W-1:0] IDX_CONFIG     = 10'h040;
    localparam logic [IDX_W-1:0] IDX_STATUS     = 10'h041;
    localparam logic [IDX_W-1:0] IDX_CORE_LOLIM = 10'h046;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK   = 10'h074;
    // Reset values
    localparam logic [7:0] RST_TARGET       = 8'h64;
    localparam logic [7:0] RST_CTRL         = 8'h00;
    localparam logic [7:0] RST_LOLIM        = 8'h00;
    localparam logic [7:0] RST_MASK         = 8'h00;
    // Control register one fields
    localparam int unsigned CTL_FAR2_CYC_MSB = 0;
    localparam int unsigned CTL_CVL_MODE     = 1;
    localparam int unsigned CTL_FAR1_CAP     = 2;
    localparam int unsigned CTL_LOCAL_CAP    = 3;
    localparam int unsigned CTL_FAR2_CAP     = 4;
    localparam int unsigned CTL_FAR1_EN      = 5;
    localparam int unsigned CTL_LOCAL_EN     = 6;
    localparam int unsigned CTL_FAR2_EN      = 7;
    // Control register two fields
    localparam int unsigned CT2_FAR1_CYC_LSB  = 0;
    localparam int unsigned CT2_LOCAL_CYC_LSB = 3;
    localparam int unsigned CT2_FAR2_CYC_LSB  = 6;
    // Config lock bit, status bits
    localparam int unsigned CFG_LOCK        = 1;
    localparam int unsigned STS_CAPTURE     = 0;
    localparam int unsigned STS_CORE_LOW    = 1;
    // Adjustment periods in monitoring cycles, shifted by the cycle code
    localparam int unsigned CYC_W           = 11;
    localparam logic [CYC_W-1:0] DEC_BASE   = 11'h004;
    localparam logic [CYC_W-1:0] INC_BASE   = 11'h008;
    // Bus responses
    localparam logic [1:0] RESP_OKAY        = 2'h0;
    localparam logic [1:0] RESP_SLVERR      = 2'h2;
endpackage

// file: design/dtc_sync2.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module dtc_sync2 #(
    parameter int unsigned W = 1
) (
    input  wire logic         clock_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] async_i,
    input  wire logic [W-1:0] rst_val_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            meta_ff <= rst_val_i;
            sync_ff <= rst_val_i;
        end else begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end

    assign sync_o = sync_ff;
endmodule // dtc_sync2

// file: verification/dtc_config_regs_monitor.sv
// Bus and control checks for the adaptive floor registers
`timescale 1ns/1ps
module dtc_config_regs_monitor (
    input wire logic        clock_i,
    input wire logic        rst_n_i,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic [11:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic [7:0]  far1_prog_floor_i,
    input wire logic [7:0]  local_prog_floor_i,
    input wire logic [7:0]  far1_floor_o,
    input wire logic [7:0]  local_floor_o,
    input wire logic [2:0]  adaptive_active_o,
    input wire logic        processor_hot_monitor_en_o,
    input wire logic        shutdown_block_o,
    input wire logic        irq_o
);
    wire logic [9:0] rd_idx = s_axi_araddr[11:2];
    wire logic       rd_map = rd_idx inside {[10'h033:10'h037], 10'h040, 10'h041, 10'h046, 10'h074};
    wire logic       wr_take = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
    wire logic       rd_take = s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    a_write_answer: assert property (wr_take |=> s_axi_bvalid && s_axi_awready)
        else $error("late write answer");
    a_aw_w_pair: assert property (s_axi_awready |-> s_axi_wready ##1 !s_axi_awready)
        else $error("aw/w ready unpaired");
    a_read_answer: assert property (rd_take |=> s_axi_rvalid && s_axi_arready)
        else $error("late read answer");
    a_unmapped_err: assert property (rd_take && !rd_map |=> s_axi_rresp == 2'h2 && s_axi_rdata == 0)
        else $error("unmapped read not refused");
    a_far1_follow: assert property ($past(rst_n_i) && !adaptive_active_o[0] |->
        far1_floor_o == $past(far1_prog_floor_i)) else $error("far1 floor moved");
    a_local_follow: assert property ($past(rst_n_i) && !adaptive_active_o[1] |->
        local_floor_o == $past(local_prog_floor_i)) else $error("local floor moved");
    a_low_blocks: assert property (shutdown_block_o |->
        adaptive_active_o == 3'h0 && !processor_hot_monitor_en_o) else $error("core low not blocking");
    a_low_release: assert property ($fell(shutdown_block_o) |-> processor_hot_monitor_en_o)
        else $error("hot monitor not restored");
    c_write: cover property (wr_take);
    c_unmapped: cover property (rd_take && !rd_map);
    c_low: cover property ($rose(shutdown_block_o) ##[1:20] irq_o);
endmodule // dtc_config_regs_monitor

bind dtc_config_regs dtc_config_regs_monitor mon_u (.clock_i, .rst_n_i, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .far1_prog_floor_i,
    .local_prog_floor_i, .far1_floor_o, .local_floor_o, .adaptive_active_o,
    .processor_hot_monitor_en_o, .shutdown_block_o, .irq_o);

// file: verification/testbench.sv
// Bench for the adaptive floor registers
`timescale 1ns/1ps
module testbench;
    logic        clock_i = 1'b0, rst_n_i = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_o, shutdown_block_o;
    logic        overheat_pin_n_i = 1'b1, standby_supply_i = 1'b0, monitor_tick_i = 1'b0;
    logic [7:0]  core_voltage_i = 8'hFF, far1_temp_i = 8'h20, local_temp_i = 8'h21;
    logic [7:0]  far2_temp_i = 8'h22, far1_low_lim_i = 8'h10, local_low_lim_i = 8'h10;
    logic [7:0]  far2_low_lim_i = 8'h10, far1_high_lim_i = 8'h7F, local_high_lim_i = 8'h7F;
    logic [7:0]  far2_high_lim_i = 8'h7F, far1_prog_floor_i = 8'h40, local_prog_floor_i = 8'h41;
    logic [7:0]  far2_prog_floor_i = 8'h40, far1_floor_o, local_floor_o, far2_floor_o;
    logic [2:0]  adaptive_active_o;
    logic        processor_hot_monitor_en_o;
    int          err_count = 0, samples_checked = 0;

    always #12.5 clock_i = ~clock_i;

    dtc_config_regs dut_u (.clock_i, .rst_n_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .overheat_pin_n_i, .standby_supply_i,
        .monitor_tick_i, .core_voltage_i, .far1_temp_i, .local_temp_i, .far2_temp_i,
        .far1_low_lim_i, .local_low_lim_i, .far2_low_lim_i, .far1_high_lim_i, .local_high_lim_i,
        .far2_high_lim_i, .far1_prog_floor_i, .local_prog_floor_i, .far2_prog_floor_i,
        .far1_floor_o, .local_floor_o, .far2_floor_o, .adaptive_active_o,
        .processor_hot_monitor_en_o, .shutdown_block_o, .irq_o);

    task automatic print_verdict();
        if (err_count == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [9:0] i, input logic [7:0] d);
        bit a = 1'b0, b = 1'b0;
        @(posedge clock_i);
        s_axi_awaddr <= {i, 2'b00};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b) begin
            @(posedge clock_i);
            if (s_axi_awready === 1'b1) begin
                a = 1'b1;
                s_axi_awvalid <= 1'b0;
                s_axi_wvalid <= 1'b0;
            end
            if (a && s_axi_bvalid === 1'b1) begin
                b = 1'b1;
                rs = s_axi_bresp;
                s_axi_bready <= 1'b0;
            end
        end
    endtask

    task automatic rdr(input logic [9:0] i);
        @(posedge clock_i);
        s_axi_araddr <= {i, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clock_i); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) @(posedge clock_i);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clock_i) monitor_tick_i <= 1'b1;
            @(posedge clock_i) monitor_tick_i <= 1'b0;
        end
        repeat (2) @(posedge clock_i);
    endtask

    task automatic pin_pulse();
        @(posedge clock_i) overheat_pin_n_i <= 1'b0;
        repeat (6) @(posedge clock_i);
        overheat_pin_n_i <= 1'b1;
        repeat (4) @(posedge clock_i);
    endtask

    initial begin
        repeat (20000) @(posedge clock_i);
        err_count++;
        print_verdict();
    end

    initial begin
        repeat (5) @(posedge clock_i);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            rdr(dtc_pkg::IDX_FAR1_TGT + 10'(i));
            chk(rd, 32'h64);
        end
        rdr(dtc_pkg::IDX_CTRL_ONE);
        chk(rd, 32'h0);
        wr(dtc_pkg::IDX_FAR1_TGT, 8'h5A);
        rdr(dtc_pkg::IDX_FAR1_TGT);
        chk(rd, 32'h5A);
        chk(far1_floor_o, 32'h40);
        wr(dtc_pkg::IDX_CTRL_ONE, 8'h14);
        pin_pulse();
        rdr(dtc_pkg::IDX_FAR1_TGT);
        chk(rd, 32'h20);
        rdr(dtc_pkg::IDX_LOCAL_TGT);
        chk(rd, 32'h64);
        rdr(dtc_pkg::IDX_FAR2_TGT);
        chk(rd, 32'h22);
        wr(dtc_pkg::IDX_CTRL_ONE, 8'h08);
        pin_pulse();
        rdr(dtc_pkg::IDX_LOCAL_TGT);
        chk(rd, 32'h21);
        wr(dtc_pkg::IDX_CORE_LOLIM, 8'h50);
        wr(dtc_pkg::IDX_IRQ_MASK, 8'h02);
        wr(dtc_pkg::IDX_CTRL_ONE, 8'hE2);
        repeat (3) @(posedge clock_i);
        chk(adaptive_active_o, 32'h7);
        standby_supply_i <= 1'b1;
        core_voltage_i <= 8'h4F;
        repeat (8) @(posedge clock_i);
        chk(shutdown_block_o, 32'h1);
        chk(processor_hot_monitor_en_o, 32'h0);
        chk(adaptive_active_o, 32'h0);
        chk(irq_o, 32'h1);
        rdr(dtc_pkg::IDX_STATUS);
        chk(rd & 32'h2, 32'h2);
        core_voltage_i <= 8'h51;
        repeat (4) @(posedge clock_i);
        chk(processor_hot_monitor_en_o, 32'h1);
        chk(adaptive_active_o, 32'h7);
        wr(dtc_pkg::IDX_STATUS, 8'h02);
        repeat (3) @(posedge clock_i);
        chk(irq_o, 32'h0);
        far2_temp_i <= 8'h70;
        wr(dtc_pkg::IDX_CTRL_ONE, 8'h81);
        tick(60);
        chk(far2_floor_o, 32'h40);
        tick(10);
        chk(far2_floor_o, 32'h3F);
        rdr(10'h3FF);
        chk(rd, 32'h0);
        chk(rs, 32'h2);
        wr(dtc_pkg::IDX_CONFIG, 8'h02);
        wr(dtc_pkg::IDX_FAR1_TGT, 8'h11);
        chk(rs, 32'h0);
        rdr(dtc_pkg::IDX_FAR1_TGT);
        chk(rd, 32'h20);
        wr(dtc_pkg::IDX_CTRL_ONE, 8'h00);
        rdr(dtc_pkg::IDX_CTRL_ONE);
        chk(rd, 32'h81);
        print_verdict();
    end
endmodule // testbench
